// ### hdl/adc_scan_pkg.sv
/*
 * Shared constants and types of the converter control block: special
 * function register addresses, control bit positions, reset values,
 * sequencer states and the bundles that carry the register bus and the
 * request to the analog conversion core.
 * Assumes an 8-bit register bus with 8-bit addresses.
 */
package adc_scan_pkg;

    // register addresses on the special function register bus
    localparam logic [7:0] ADDR_PINS   = 8'hC7;
    localparam logic [7:0] ADDR_CTRL   = 8'hD7;
    localparam logic [7:0] ADDR_SELECT = 8'hE7;
    localparam logic [7:0] ADDR_HIGH   = 8'hF7;

    // low-byte result registers sit at 8'h86 + 8'h10 * n, n = 0 to 7
    localparam logic [3:0] LOW_BYTE_LOW_NIBBLE = 4'h6;
    localparam int unsigned LOW_BYTE_MARK_BIT  = 7;
    localparam int unsigned LOW_BYTE_CH_LSB    = 4;

    // sizes
    localparam int unsigned CH_COUNT = 8;
    localparam int unsigned RES_W    = 10;

    // converter_control bit positions
    localparam int unsigned CTRL_PRESCALE_HI = 7;
    localparam int unsigned CTRL_PRESCALE_LO = 6;
    localparam int unsigned CTRL_RESERVED    = 5;
    localparam int unsigned CTRL_DONE        = 4;
    localparam int unsigned CTRL_START       = 3;
    localparam int unsigned CTRL_CONTINUOUS  = 2;
    localparam int unsigned CTRL_RISE_EN     = 1;
    localparam int unsigned CTRL_FALL_EN     = 0;

    // values after reset
    localparam logic [1:0] PRESCALE_RESET = 2'h0;
    localparam logic [7:0] SELECT_RESET   = 8'h00;
    localparam logic [1:0] HIGH_RESET     = 2'h0;
    localparam logic [7:0] RDATA_RESET    = 8'h00;

    // converter clock divisor for each prescale selection
    localparam logic [3:0] PRESCALE_DIVISOR [0:3] = '{4'h2, 4'h4, 4'h6, 4'h8};

    // synchroniser depth for pin inputs, plus one stage for edge history
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [2:0]  PRIME_FULL  = 3'h7;

    // scan sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } scan_state_e;

    // register bus request from the cpu core
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_s;

    // request to the analog conversion core
    typedef struct packed {
        logic       start;
        logic       abort;
        logic [2:0] channel;
    } conv_req_s;

endpackage

// ### hdl/trigger_edge_detect.sv
/*
 * Synchroniser and edge detector for the external trigger input.
 * Assumes the input is asynchronous to i_clock; edges are reported as
 * one-cycle pulses, none during the first cycles after reset release.
 */
`timescale 1ns/1ps
module trigger_edge_detect (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_resetn,
    // raw level from the pin
    input  wire logic i_level,
    // edge pulses
    output logic      o_rise,
    output logic      o_fall
);

    logic       meta_ff;
    logic       sync_ff;
    logic       prev_ff;
    logic [2:0] prime_ff;
    logic [2:0] nxt_prime;

    // history must be filled before edges count, else reset looks like an edge
    always_comb begin
        nxt_prime = {prime_ff[1:0], 1'b1};
    end

    // two-stage synchroniser, then one sample of history
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff  <= 1'b0;
            sync_ff  <= 1'b0;
            prev_ff  <= 1'b0;
            prime_ff <= 3'h0;
        end else begin
            meta_ff  <= i_level;
            sync_ff  <= meta_ff;
            prev_ff  <= sync_ff;
            prime_ff <= nxt_prime;
        end
    end

    // compare two successive synchronised samples
    assign o_rise = (prime_ff == adc_scan_pkg::PRIME_FULL) && sync_ff && !prev_ff;
    assign o_fall = (prime_ff == adc_scan_pkg::PRIME_FULL) && !sync_ff && prev_ff;

endmodule

// ### hdl/adc_scan_control_regs.sv
/*
 * Control, status and result access of an eight-channel 10-bit converter.
 * Holds converter_control, scan_channel_select, result_high_bits, the
 * per-channel results and the digital view of the shared pins, and runs
 * the autoscan sequencer that drives the analog conversion core.
 * Assumes the cpu core issues single-cycle read and write strobes on the
 * special function register bus, the conversion core answers each start
 * with one done pulse, and i_power_down is a level on i_clock.
 */
`timescale 1ns/1ps

module adc_scan_control_regs (
    // clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_resetn,
    // special function register bus
    input  wire adc_scan_pkg::sfr_req_s  i_sfr,
    output logic [7:0]                   o_sfr_rdata,
    // shared pins and trigger
    input  wire logic [7:0]              i_pins,
    input  wire logic                    i_external_trigger_input,
    // analog conversion core
    output adc_scan_pkg::conv_req_s      o_conv,
    input  wire logic                    i_conv_done,
    input  wire logic [9:0]              i_conv_result,
    output logic [3:0]                   o_prescale_divisor,
    // system
    input  wire logic                    i_power_down,
    input  wire logic                    i_irq_enable,
    output logic                         o_irq,
    output logic                         o_capture
);

    adc_scan_pkg::scan_state_e state_ff, nxt_state;
    logic [2:0] channel_ff, nxt_channel;
    logic [7:0] loop_mask_ff, nxt_loop_mask;
    logic       start_ff, nxt_start;
    logic       done_ff, nxt_done;
    logic       conv_start_ff, nxt_conv_start;
    logic       conv_abort_ff, nxt_conv_abort;
    logic       capture_ff, nxt_capture;
    logic [1:0] prescale_ff, nxt_prescale;
    logic       cont_ff, nxt_cont;
    logic       rise_en_ff, nxt_rise_en;
    logic       fall_en_ff, nxt_fall_en;
    logic [7:0] select_ff, nxt_select;
    logic [1:0] high_ff, nxt_high;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [7:0] pin_meta_ff;
    logic [7:0] pin_sync_ff;
    logic [9:0] result_ff [adc_scan_pkg::CH_COUNT];

    logic       trig_rise, trig_fall, trig_start;
    logic       ctrl_wr, sw_set_start, sw_clear_start;
    logic       start_req, stop, loop_done, store;
    logic       low_byte_rd;
    logic [2:0] low_ch;
    logic [1:0] low_pick;
    logic [3:0] first_pick, next_pick, reload_pick;

    // lowest selected channel at or above a start point; bit 3 set means none
    function automatic logic [3:0] pick_channel(input logic [7:0] mask,
                                                input logic [3:0] from);
        logic [3:0] pick;
        pick = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && (4'(i) >= from)) begin
                pick = 4'(i);
            end
        end
        return pick;
    endfunction

    trigger_edge_detect trigger_edge_detect_inst (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_level  (i_external_trigger_input),
        .o_rise   (trig_rise),
        .o_fall   (trig_fall)
    );

    // request decode
    assign ctrl_wr        = i_sfr.wr && (i_sfr.addr == adc_scan_pkg::ADDR_CTRL);
    assign sw_set_start   = ctrl_wr && i_sfr.wdata[adc_scan_pkg::CTRL_START];
    assign sw_clear_start = ctrl_wr && !i_sfr.wdata[adc_scan_pkg::CTRL_START];
    assign trig_start     = (trig_rise && rise_en_ff)
                          || (trig_fall && fall_en_ff);
    // a start is only taken from a stopped, powered block with a mask
    assign start_req = (sw_set_start || (!ctrl_wr && trig_start))
                     && !start_ff && (select_ff != 8'h00) && !i_power_down;
    // software clear or power reduction ends the scan
    assign stop = start_ff && (sw_clear_start || i_power_down);

    // low-byte result address decode: 8'h86, 8'h96 ... 8'hF6
    assign low_byte_rd = i_sfr.rd && i_sfr.addr[adc_scan_pkg::LOW_BYTE_MARK_BIT]
                       && (i_sfr.addr[3:0] == adc_scan_pkg::LOW_BYTE_LOW_NIBBLE);
    assign low_ch   = i_sfr.addr[adc_scan_pkg::LOW_BYTE_CH_LSB +: 3];
    assign low_pick = result_ff[low_ch][9:8];

    // channel search; ascending order falls out of picking the lowest
    assign first_pick  = pick_channel(select_ff, 4'h0);
    assign next_pick   = pick_channel(loop_mask_ff, {1'b0, channel_ff} + 4'h1);
    assign reload_pick = first_pick;

    // autoscan sequencer next state
    always_comb begin
        nxt_state      = state_ff;
        nxt_channel    = channel_ff;
        nxt_loop_mask  = loop_mask_ff;
        nxt_conv_start = 1'b0;
        nxt_conv_abort = 1'b0;
        loop_done      = 1'b0;
        store          = 1'b0;
        case (state_ff)
            adc_scan_pkg::ST_IDLE: begin
                if (start_req) begin
                    nxt_loop_mask = select_ff;  // mask frozen per loop
                    nxt_channel   = first_pick[2:0];
                    nxt_state     = adc_scan_pkg::ST_ISSUE;
                end
            end
            adc_scan_pkg::ST_ISSUE: begin
                nxt_conv_start = 1'b1;
                nxt_state      = adc_scan_pkg::ST_WAIT;
            end
            adc_scan_pkg::ST_WAIT: begin
                if (i_conv_done) begin
                    store = 1'b1;
                    if (!next_pick[3]) begin
                        nxt_channel = next_pick[2:0];  // skip unselected
                        nxt_state   = adc_scan_pkg::ST_ISSUE;
                    end else begin
                        loop_done = 1'b1;
                        // new mask only picked up here, at the loop boundary
                        if (cont_ff && (select_ff != 8'h00)) begin
                            nxt_loop_mask = select_ff;
                            nxt_channel   = reload_pick[2:0];
                            nxt_state     = adc_scan_pkg::ST_ISSUE;
                        end else begin
                            nxt_state = adc_scan_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                nxt_state = adc_scan_pkg::ST_IDLE;
            end
        endcase
        // abort beats a completion in the same cycle; its result is dropped
        if (stop) begin
            nxt_state      = adc_scan_pkg::ST_IDLE;
            nxt_conv_start = 1'b0;
            nxt_conv_abort = (state_ff != adc_scan_pkg::ST_IDLE);
            loop_done      = 1'b0;
            store          = 1'b0;
        end
    end

    // start bit and scan done flag next values
    always_comb begin
        nxt_start = start_ff;
        if (start_req) begin
            nxt_start = 1'b1;
        end
        if (loop_done && (nxt_state == adc_scan_pkg::ST_IDLE)) begin
            nxt_start = 1'b0;  // one-time pass over, or continuous with no mask
        end
        if (stop) begin
            nxt_start = 1'b0;
        end
        nxt_done = done_ff;
        if (ctrl_wr && !i_sfr.wdata[adc_scan_pkg::CTRL_DONE]) begin
            nxt_done = 1'b0;  // a written one is simply ignored
        end
        if (loop_done) begin
            nxt_done = 1'b1;  // set wins over a clear in the same cycle
        end
        nxt_capture = trig_start;  // capture even when the start is refused
    end

    // sequencer and status registers; control state cleared by reset
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff      <= adc_scan_pkg::ST_IDLE;
            channel_ff    <= 3'h0;
            loop_mask_ff  <= adc_scan_pkg::SELECT_RESET;
            start_ff      <= 1'b0;
            done_ff       <= 1'b0;
            conv_start_ff <= 1'b0;
            conv_abort_ff <= 1'b0;
            capture_ff    <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            channel_ff    <= nxt_channel;
            loop_mask_ff  <= nxt_loop_mask;
            start_ff      <= nxt_start;
            done_ff       <= nxt_done;
            conv_start_ff <= nxt_conv_start;
            conv_abort_ff <= nxt_conv_abort;
            capture_ff    <= nxt_capture;
        end
    end

    // configuration writes; bit 5 is not stored, software keeps it zero
    always_comb begin
        nxt_prescale = prescale_ff;
        nxt_cont     = cont_ff;
        nxt_rise_en  = rise_en_ff;
        nxt_fall_en  = fall_en_ff;
        nxt_select   = select_ff;
        if (ctrl_wr) begin
            nxt_prescale = i_sfr.wdata[adc_scan_pkg::CTRL_PRESCALE_HI:
                                       adc_scan_pkg::CTRL_PRESCALE_LO];
            nxt_cont     = i_sfr.wdata[adc_scan_pkg::CTRL_CONTINUOUS];
            nxt_rise_en  = i_sfr.wdata[adc_scan_pkg::CTRL_RISE_EN];
            nxt_fall_en  = i_sfr.wdata[adc_scan_pkg::CTRL_FALL_EN];
        end
        if (i_sfr.wr && (i_sfr.addr == adc_scan_pkg::ADDR_SELECT)) begin
            nxt_select = i_sfr.wdata;
        end
    end

    // configuration registers, all zero after reset
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            prescale_ff <= adc_scan_pkg::PRESCALE_RESET;  // divide by 2
            cont_ff     <= 1'b0;
            rise_en_ff  <= 1'b0;
            fall_en_ff  <= 1'b0;
            select_ff   <= adc_scan_pkg::SELECT_RESET;
        end else begin
            prescale_ff <= nxt_prescale;
            cont_ff     <= nxt_cont;
            rise_en_ff  <= nxt_rise_en;
            fall_en_ff  <= nxt_fall_en;
            select_ff   <= nxt_select;
        end
    end

    // read mux; data answers one cycle after the read strobe
    always_comb begin
        nxt_high  = high_ff;
        nxt_rdata = 8'h00;  // unmapped addresses read zero
        if (i_sfr.rd) begin
            case (i_sfr.addr)
                adc_scan_pkg::ADDR_PINS: begin
                    nxt_rdata = pin_sync_ff;  // pure read, no side effect
                end
                adc_scan_pkg::ADDR_CTRL: begin
                    nxt_rdata = {prescale_ff, 1'b0, done_ff, start_ff,
                                 cont_ff, rise_en_ff, fall_en_ff};
                end
                adc_scan_pkg::ADDR_SELECT: begin
                    nxt_rdata = select_ff;
                end
                adc_scan_pkg::ADDR_HIGH: begin
                    nxt_rdata = {6'h00, high_ff};
                end
                default: begin
                    if (low_byte_rd) begin
                        nxt_rdata = result_ff[low_ch][7:0];
                        nxt_high  = low_pick;  // held until the next low-byte read
                    end
                end
            endcase
        end
    end

    // read data and latched upper result bits
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            high_ff  <= adc_scan_pkg::HIGH_RESET;
            rdata_ff <= adc_scan_pkg::RDATA_RESET;
        end else begin
            high_ff  <= nxt_high;
            rdata_ff <= nxt_rdata;
        end
    end

    // pin view: two-stage sync with no reset so reset leaves it alone
    always_ff @(posedge i_clock) begin
        pin_meta_ff <= i_pins;
        pin_sync_ff <= pin_meta_ff;
    end

    // per-channel result storage; no reset so results survive it
    for (genvar g = 0; g < adc_scan_pkg::CH_COUNT; g++) begin : g_result
        logic [9:0] nxt_result;
        always_comb begin
            nxt_result = result_ff[g];
            if (store && (channel_ff == 3'(g))) begin
                nxt_result = i_conv_result;
            end
        end
        always_ff @(posedge i_clock) begin
            result_ff[g] <= nxt_result;
        end
    end

    // outputs
    assign o_sfr_rdata        = rdata_ff;
    assign o_conv             = '{start: conv_start_ff, abort: conv_abort_ff,
                                  channel: channel_ff};
    assign o_prescale_divisor = adc_scan_pkg::PRESCALE_DIVISOR[prescale_ff];
    assign o_irq              = done_ff && i_irq_enable;
    assign o_capture          = capture_ff;

    // checks on the upper result register
    a_high_upper_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_sfr.rd && (i_sfr.addr == adc_scan_pkg::ADDR_HIGH)) |=> (o_sfr_rdata[7:2] == 6'h00))
        else $error("upper result register read nonzero high bits");
    a_high_bits_latch: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (low_byte_rd |=> (high_ff == $past(low_pick))) and ((i_sfr.rd && (i_sfr.addr ==
        adc_scan_pkg::ADDR_HIGH)) |=> (o_sfr_rdata[1:0] == $past(high_ff))))
        else $error("upper bits not latched from the low-byte read");

    // checks on starting and stopping
    a_no_start_empty: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (!start_ff && (select_ff == 8'h00)) |=> !start_ff)
        else $error("scan started with an empty channel mask");
    a_start_taken: assert property (@(posedge i_clock) disable iff (!i_resetn)
        start_req |=> start_ff ##1 (o_conv.start || !start_ff))
        else $error("start request did not begin a conversion");
    a_ignore_restart: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ((state_ff == adc_scan_pkg::ST_WAIT) && !i_conv_done && !stop)
        |=> ($stable(channel_ff) && $stable(loop_mask_ff) && start_ff))
        else $error("running scan disturbed by a start or mask write");
    a_abort_on_stop: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (stop && (state_ff != adc_scan_pkg::ST_IDLE))
        |=> (o_conv.abort && !start_ff && (state_ff == adc_scan_pkg::ST_IDLE)))
        else $error("clearing start did not abort the conversion");
    a_oneshot_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (loop_done && !cont_ff) |=> !start_ff)
        else $error("one-time scan left the start bit set");
    a_cont_keeps: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (loop_done && cont_ff && (select_ff != 8'h00)) |=> (start_ff ##1 (o_conv.start || !start_ff)))
        else $error("continuous scan did not restart");

    // checks on channel choice and flags
    a_scan_skips: assert property (@(posedge i_clock) disable iff (!i_resetn)
        o_conv.start |-> loop_mask_ff[o_conv.channel])
        else $error("unselected channel was converted");
    a_scan_ascends: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ((state_ff == adc_scan_pkg::ST_WAIT) && i_conv_done && !stop && !next_pick[3])
        |=> (channel_ff > $past(channel_ff)))
        else $error("channel order broken");
    a_done_sets_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
        loop_done |=> (done_ff && (o_irq == i_irq_enable)))
        else $error("scan done flag or interrupt missing after loop");
    a_flag_no_sw_set: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (!done_ff && !loop_done) |=> !done_ff)
        else $error("scan done flag set without a finished loop");
    a_capture_edges: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ((trig_rise && rise_en_ff) || (trig_fall && fall_en_ff)) |=> o_capture)
        else $error("enabled trigger edge gave no capture pulse");

endmodule

// ### tb/conv_core_model.sv
/* conversion core stand-in: one done pulse per start after i_delay+1 cycles.
   assumes one start at a time; the result is derived from the channel. */
`timescale 1ns/1ps
module conv_core_model (
    // clock and request
    input  wire logic                    i_clock,
    input  wire adc_scan_pkg::conv_req_s i_conv,
    input  wire logic [3:0]              i_delay,
    // answer
    output logic                         o_done,
    output logic [9:0]                   o_result
);
    logic       busy = 1'b0;
    logic [3:0] cnt  = 4'h0;
    logic [9:0] val  = 10'h000;
    initial o_done = 1'b0;
    // abort drops the pending answer so no late done leaks out
    always @(posedge i_clock) begin
        o_done <= 1'b0;
        if (i_conv.abort) begin
            busy <= 1'b0;
        end else if (i_conv.start) begin
            busy <= 1'b1;
            cnt  <= i_delay;
            val  <= {i_conv.channel, 2'h1, i_conv.channel, 2'h2};
        end else if (busy) begin
            cnt    <= cnt - 4'h1;
            busy   <= (cnt != 4'h0);
            o_done <= (cnt == 4'h0);
        end
    end
    // outside the done cycle show the inverse, never the stale value
    assign o_result = o_done ? val : ~val;
endmodule

// ### tb/adc_scan_control_regs_tb.sv
/* random-mask scans, trigger edges and register checks for the block.
   assumes conv_core_model answers in place of the analog core. */
`timescale 1ns/1ps
module adc_scan_control_regs_tb;
    logic                    i_clock = 1'b0;
    logic                    i_resetn = 1'b0;
    adc_scan_pkg::sfr_req_s  sfr = '0;
    adc_scan_pkg::conv_req_s conv;
    logic [7:0]              pins = 8'h00, bus_q, rv, mask;
    logic                    trig = 1'b0, irq_en = 1'b1, pd = 1'b0, done, irq, cap;
    logic [9:0]              res, e;
    logic [3:0]              dly = 4'h3, div;
    logic [2:0]              order[$];
    int                      failures = 0, checks_done = 0, caps = 0, aborts = 0;
    int                      seed = 32'hea79, n, k;
    always #5 i_clock = ~i_clock;
    // record every start and capture the design issues
    always @(posedge i_clock) begin
        if (conv.start === 1'b1) order.push_back(conv.channel);
        if (cap === 1'b1) caps++;
        if (conv.abort === 1'b1) aborts++;
    end
    adc_scan_control_regs adc_scan_control_regs_inst (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_sfr(sfr), .o_sfr_rdata(bus_q), .i_pins(pins), .i_external_trigger_input(trig),
        .o_conv(conv), .i_conv_done(done), .i_conv_result(res), .o_prescale_divisor(div),
        .i_power_down(pd), .i_irq_enable(irq_en), .o_irq(irq), .o_capture(cap));
    conv_core_model conv_core_model_inst (.i_clock(i_clock), .i_conv(conv), .i_delay(dly),
        .o_done(done), .o_result(res));
    task automatic summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [9:0] g, input logic [9:0] x);
        checks_done++;
        if (g !== x) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask
    // one-cycle strobes, driven on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock) sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge i_clock) sfr.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge i_clock) sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge i_clock) sfr.rd = 1'b0;
        rv = bus_q;
    endtask
    // poll until the start bit drops, bounded
    task automatic wait_idle;
        rv = 8'h08;
        for (int t = 0; t < 300 && rv[3] !== 1'b0; t++) rd(adc_scan_pkg::ADDR_CTRL);
        if (rv[3] !== 1'b0) begin
            failures++;
            summarize();
        end
    endtask
    initial begin
        repeat (4) @(negedge i_clock);
        i_resetn = 1'b1;
        rd(adc_scan_pkg::ADDR_CTRL);
        chk({2'h0, rv}, 10'h000);
        rd(adc_scan_pkg::ADDR_SELECT);
        chk({2'h0, rv}, 10'h000);
        rd(adc_scan_pkg::ADDR_HIGH);
        chk({2'h0, rv}, 10'h000);
        for (n = 0; n < 4; n++) begin
            wr(adc_scan_pkg::ADDR_CTRL, {n[1:0], 6'h00}); // bit 5 kept zero
            chk({6'h00, div}, 10'(2 * n + 2));
        end
        wr(adc_scan_pkg::ADDR_CTRL, 8'h08);
        repeat (4) @(negedge i_clock);
        chk(10'(order.size()), 10'h000);
        for (k = 0; k < 4; k++) begin
            mask = (k == 0) ? 8'h81 : 8'($random(seed)) | 8'h01;
            pins = 8'($random(seed)); // levels only read back, never converted
            dly = 4'($random(seed)) & 4'h7;
            wr(adc_scan_pkg::ADDR_SELECT, mask);
            wr(adc_scan_pkg::ADDR_CTRL, 8'h08);
            rd(adc_scan_pkg::ADDR_PINS);
            chk({2'h0, rv}, {2'h0, pins});
            wait_idle();
            chk(10'(order.size()), 10'($countones(mask)));
            for (n = 0; n < 8; n++) if (mask[n]) begin
                e = {n[2:0], 2'h1, n[2:0], 2'h2};
                chk({7'h00, order.pop_front()}, 10'(n));
                rd(8'h86 + 8'(n * 16));
                chk({2'h0, rv}, {2'h0, e[7:0]});
                rd(adc_scan_pkg::ADDR_HIGH);
                chk({2'h0, rv}, {8'h00, e[9:8]});
            end
            rd(adc_scan_pkg::ADDR_CTRL);
            chk({9'h000, rv[4]}, 10'h001);
            chk({9'h000, irq}, 10'h001);
            irq_en = 1'b0;
            @(negedge i_clock);
            chk({9'h000, irq}, 10'h000);
            irq_en = 1'b1;
            wr(adc_scan_pkg::ADDR_CTRL, 8'h10);
            rd(adc_scan_pkg::ADDR_CTRL);
            chk({9'h000, rv[4]}, 10'h001);
            wr(adc_scan_pkg::ADDR_CTRL, 8'h00);
            rd(adc_scan_pkg::ADDR_CTRL);
            chk({9'h000, rv[4]}, 10'h000);
        end
        wr(adc_scan_pkg::ADDR_CTRL, 8'h02);
        trig = 1'b1;
        repeat (8) @(negedge i_clock);
        chk(10'(caps), 10'h001);
        wait_idle();
        chk(10'(order.size()), 10'($countones(mask)));
        order.delete();
        trig = 1'b0;
        repeat (8) @(negedge i_clock);
        chk(10'(caps), 10'h001);
        wr(adc_scan_pkg::ADDR_CTRL, 8'h01);
        trig = 1'b1;
        repeat (8) @(negedge i_clock);
        chk(10'(caps), 10'h001);
        trig = 1'b0;
        repeat (8) @(negedge i_clock);
        chk(10'(caps), 10'h002);
        wait_idle();
        chk(10'(order.size()), 10'($countones(mask)));
        dly = 4'hF;
        wr(adc_scan_pkg::ADDR_CTRL, 8'h0C);
        repeat (200) @(negedge i_clock);
        rd(adc_scan_pkg::ADDR_CTRL);
        chk({8'h00, rv[4:3]}, 10'h003);
        wr(adc_scan_pkg::ADDR_CTRL, 8'h04);
        n = order.size();
        repeat (40) @(negedge i_clock);
        chk(10'(order.size()), 10'(n));
        rd(adc_scan_pkg::ADDR_CTRL);
        chk({9'h000, rv[3]}, 10'h000);
        chk(10'(aborts), 10'h001);
        // power reduction mid-scan, then a start that must be refused
        wr(adc_scan_pkg::ADDR_CTRL, 8'h0C);
        repeat (30) @(negedge i_clock);
        pd = 1'b1;
        repeat (4) @(negedge i_clock);
        rd(adc_scan_pkg::ADDR_CTRL);
        chk({9'h000, rv[3]}, 10'h000);
        n = order.size();
        wr(adc_scan_pkg::ADDR_CTRL, 8'h08);
        repeat (20) @(negedge i_clock);
        chk(10'(order.size()), 10'(n));
        chk(10'(aborts), 10'h002);
        pd = 1'b0;
        // reset with the scan stopped: control cleared, results and pins kept
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clock);
        i_resetn = 1'b1;
        rd(adc_scan_pkg::ADDR_CTRL);
        chk({2'h0, rv}, 10'h000);
        rd(adc_scan_pkg::ADDR_SELECT);
        chk({2'h0, rv}, 10'h000);
        rd(8'h86);
        chk({2'h0, rv}, 10'h022);
        rd(adc_scan_pkg::ADDR_PINS);
        chk({2'h0, rv}, {2'h0, pins});
        summarize();
    end
endmodule
